// File: hw/wwdt_params.svh
// offsets, field positions, reset values and counts of the windowed watchdog
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH
`define WWDT_OFF_CTRL 32'h0000_0000
`define WWDT_OFF_RELOAD 32'h0000_0004
`define WWDT_OFF_WINB 32'h0000_0008
`define WWDT_OFF_SERVICE 32'h0000_000C
`define WWDT_OFF_COUNT 32'h0000_0010
`define WWDT_OFF_IRQ_STAT 32'h0000_0014
`define WWDT_OFF_IRQ_CLR 32'h0000_0018
`define WWDT_OFF_IRQ_EN 32'h0000_001C
`define WWDT_CTRL_PSEL 0
`define WWDT_CTRL_WINEN 1
`define WWDT_CTRL_DSUSP 2
`define WWDT_CTRL_RST 3'h4
`define WWDT_RELOAD_RST 8'h00
`define WWDT_WINB_RST 8'h00
`define WWDT_IRQ_EN_RST 3'h0
`define WWDT_IRQ_OVF 0
`define WWDT_IRQ_INV 1
`define WWDT_IRQ_RST 2
`define WWDT_PREWARN_LAST 6'h2F
`define WWDT_DIV_SLOW_LAST 7'h7F
`define WWDT_RESP_OKAY 2'h0
`define WWDT_RESP_SLVERR 2'h2
`endif

// File: hw/wwdt_pkg.sv
// types of the windowed watchdog
package wwdt_pkg;
    typedef enum logic [1:0] {WWDT_RUN, WWDT_PREWARN, WWDT_RESET} wwdt_state_t;
    typedef logic [7:0] wwdt_byte_t;
endpackage : wwdt_pkg

// File: hw/wwdt_cnt_if.sv
// signals shared by the watchdog prescaler, counter and control
`timescale 1ns/1ps
`default_nettype none
interface wwdt_cnt_if;
    logic run;
    logic sel;
    logic tick;
    logic service;
    logic [7:0] reload;
    logic [15:0] count;
    logic ovf;
    modport pre (input run, input sel, output tick);
    modport cnt (input tick, input service, input reload, output count, output ovf);
endinterface : wwdt_cnt_if
`default_nettype wire

// File: hw/wwdt_prescaler.sv
// count-rate prescaler: one tick per 2 or per 128 enabled clocks
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_params.svh"
module wwdt_prescaler (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    wwdt_cnt_if.pre pif
);
    logic [6:0] div_r;
    wire last = pif.sel ? (div_r == `WWDT_DIV_SLOW_LAST) : div_r[0];

    assign pif.tick = ce && pif.run && last;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 7'h00;
        end else if (ce && pif.run) begin
            div_r <= div_r + 7'h01;
        end
    end

    chk_fast_rate: assert property (
        @(posedge mclk) disable iff (!rst_n) pif.tick && !pif.sel |=> !pif.tick)
        else $error("fast rate ticked twice in a row");
    chk_slow_rate: assert property (
        @(posedge mclk) disable iff (!rst_n) pif.tick && pif.sel |=> (!pif.tick || !pif.sel) [*8])
        else $error("slow rate ticked too soon");
endmodule : wwdt_prescaler
`default_nettype wire

// File: hw/wwdt_counter.sv
// 16-bit watchdog counter built from two chained byte stages
`timescale 1ns/1ps
`default_nettype none
module wwdt_counter (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    wwdt_cnt_if.cnt cif
);
    logic [7:0] low_r;
    logic [7:0] high_r;
    wire low_carry = &low_r;

    assign cif.count = {high_r, low_r};
    assign cif.ovf = cif.tick && low_carry && (&high_r);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_r <= 8'h00;
            high_r <= 8'h00;
        end else if (ce && cif.service) begin
            high_r <= cif.reload;
            low_r <= 8'h00;
        end else if (cif.tick) begin
            low_r <= low_r + 8'h01;
            if (low_carry) begin
                high_r <= high_r + 8'h01;
            end
        end
    end

    chk_service_load: assert property (
        @(posedge mclk) disable iff (!rst_n) ce && cif.service |=> cif.count == {$past(cif.reload), 8'h00})
        else $error("service did not preset the counter");
    chk_count_step: assert property (
        @(posedge mclk) disable iff (!rst_n) cif.tick && !cif.service |=> cif.count == $past(cif.count) + 16'h0001)
        else $error("counter did not advance by one");
endmodule : wwdt_counter
`default_nettype wire

// File: hw/wwdt_top.sv
// windowed watchdog with axi4-lite registers, nmi and system reset request
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_params.svh"
module wwdt_top
    import wwdt_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic debug_mode,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic watchdog_nmi_request,
    output logic watchdog_system_reset_request,
    output logic irq
);
    function automatic logic wwdt_mapped(input logic [31:0] a);
        return (a[31:5] == 27'h000_0000) && (a[1:0] == 2'h0);
    endfunction : wwdt_mapped

    function automatic logic wwdt_hit(input logic [31:0] a, input logic [31:0] off);
        return a == off;
    endfunction : wwdt_hit

    // reset release synchroniser
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else if (ce) begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // debug_mode comes from another domain
    logic dbg_s1_r;
    logic dbg_s2_r;
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dbg_s1_r <= 1'b0;
            dbg_s2_r <= 1'b0;
        end else if (ce) begin
            dbg_s1_r <= debug_mode;
            dbg_s2_r <= dbg_s1_r;
        end
    end

    logic psel_r;
    logic winen_r;
    logic dsusp_r;
    wwdt_byte_t reload_r;
    wwdt_byte_t winb_r;
    logic [2:0] ien_r;
    logic [2:0] ist_r;
    wwdt_state_t st_r;
    wwdt_state_t st_nxt;
    logic [5:0] pw_cnt_r;

    // axi write channel
    logic aw_got_r;
    logic w_got_r;
    logic [31:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
    wire aw_got_nxt = wr_do ? 1'b0 : (aw_got_r || aw_take);
    wire w_got_nxt = wr_do ? 1'b0 : (w_got_r || w_take);
    // only byte lane 0 carries register bits
    wire wr_lane0 = wr_do && wstrb_r[0];
    wire wr_ctrl = wr_lane0 && wwdt_hit(waddr_r, `WWDT_OFF_CTRL);
    wire wr_reload = wr_lane0 && wwdt_hit(waddr_r, `WWDT_OFF_RELOAD);
    wire wr_winb = wr_lane0 && wwdt_hit(waddr_r, `WWDT_OFF_WINB);
    wire wr_svc = wr_lane0 && wwdt_hit(waddr_r, `WWDT_OFF_SERVICE);
    wire wr_iclr = wr_lane0 && wwdt_hit(waddr_r, `WWDT_OFF_IRQ_CLR);
    wire wr_ien = wr_lane0 && wwdt_hit(waddr_r, `WWDT_OFF_IRQ_EN);

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            waddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (ce) begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            s_axi_awready <= !aw_got_nxt;
            s_axi_wready <= !w_got_nxt;
            if (aw_take) begin
                waddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WWDT_RESP_OKAY;
        end else if (ce) begin
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wwdt_mapped(waddr_r) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // counter path
    wwdt_cnt_if cif ();
    wire in_run = (st_r == WWDT_RUN);
    wire in_pw = (st_r == WWDT_PREWARN);
    wire suspended = dsusp_r && dbg_s2_r;
    wire inval = winen_r && (cif.count <= {winb_r, 8'h00});
    // a late service is the software's fault; the overflow below catches it
    wire svc_fire = wr_svc && in_run && !inval;
    wire inv_fire = wr_svc && in_run && inval;
    wire ovf_fire = cif.ovf && in_run && !wr_svc;
    wire pw_end = in_pw && cif.tick && (pw_cnt_r == `WWDT_PREWARN_LAST);
    wire [5:0] pw_cnt_nxt = !in_pw ? 6'h00 : (cif.tick ? pw_cnt_r + 6'h01 : pw_cnt_r);

    assign cif.run = !suspended;
    assign cif.sel = psel_r;
    assign cif.reload = reload_r;
    assign cif.service = svc_fire;

    wwdt_prescaler u_pre (
        .mclk(mclk),
        .rst_n(rst_n_r),
        .ce(ce),
        .pif(cif)
    );

    wwdt_counter u_cnt (
        .mclk(mclk),
        .rst_n(rst_n_r),
        .ce(ce),
        .cif(cif)
    );

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            WWDT_RUN: begin
                if (inv_fire || ovf_fire) begin
                    st_nxt = WWDT_PREWARN;
                end
            end
            WWDT_PREWARN: begin
                if (pw_end) begin
                    st_nxt = WWDT_RESET;
                end
            end
            WWDT_RESET: begin
                st_nxt = WWDT_RESET;
            end
        endcase
    end

    // the reset request holds until the system reset reinitialises the block
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= WWDT_RUN;
            pw_cnt_r <= 6'h00;
            watchdog_nmi_request <= 1'b0;
            watchdog_system_reset_request <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            pw_cnt_r <= pw_cnt_nxt;
            watchdog_nmi_request <= watchdog_nmi_request || ovf_fire;
            watchdog_system_reset_request <= watchdog_system_reset_request || pw_end;
        end
    end

    // configuration and interrupt registers
    wire [2:0] ev = {pw_end, inv_fire, ovf_fire};
    wire [2:0] clr_mask = wr_iclr ? wdata_r[2:0] : 3'h0;
    // set wins over a clear in the same cycle
    wire [2:0] ist_nxt = (ist_r & ~clr_mask) | ev;

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            {dsusp_r, winen_r, psel_r} <= `WWDT_CTRL_RST;
            reload_r <= `WWDT_RELOAD_RST;
            winb_r <= `WWDT_WINB_RST;
            ien_r <= `WWDT_IRQ_EN_RST;
            ist_r <= 3'h0;
            irq <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                psel_r <= wdata_r[`WWDT_CTRL_PSEL];
                winen_r <= wdata_r[`WWDT_CTRL_WINEN];
                dsusp_r <= wdata_r[`WWDT_CTRL_DSUSP];
            end
            if (wr_reload) begin
                reload_r <= wdata_r[7:0];
            end
            if (wr_winb) begin
                winb_r <= wdata_r[7:0];
            end
            if (wr_ien) begin
                ien_r <= wdata_r[2:0];
            end
            ist_r <= ist_nxt;
            irq <= |(ist_r & ien_r);
        end
    end

    // axi read channel
    logic ar_got_r;
    logic [31:0] raddr_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_do = ar_got_r && !s_axi_rvalid;
    wire ar_got_nxt = rd_do ? 1'b0 : (ar_got_r || ar_take);
    wire [31:0] cnt_word = {13'h0000, watchdog_nmi_request, watchdog_system_reset_request, in_pw, cif.count};
    wire [31:0] rd_val =
        wwdt_hit(raddr_r, `WWDT_OFF_CTRL) ? {29'h0000_0000, dsusp_r, winen_r, psel_r} :
        wwdt_hit(raddr_r, `WWDT_OFF_RELOAD) ? {24'h00_0000, reload_r} :
        wwdt_hit(raddr_r, `WWDT_OFF_WINB) ? {24'h00_0000, winb_r} :
        wwdt_hit(raddr_r, `WWDT_OFF_COUNT) ? cnt_word :
        wwdt_hit(raddr_r, `WWDT_OFF_IRQ_STAT) ? {29'h0000_0000, ist_r} :
        wwdt_hit(raddr_r, `WWDT_OFF_IRQ_EN) ? {29'h0000_0000, ien_r} :
        32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ar_got_r <= 1'b0;
            s_axi_arready <= 1'b0;
            raddr_r <= 32'h0000_0000;
        end else if (ce) begin
            ar_got_r <= ar_got_nxt;
            s_axi_arready <= !ar_got_nxt;
            if (ar_take) begin
                raddr_r <= s_axi_araddr;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `WWDT_RESP_OKAY;
        end else if (ce) begin
            if (rd_do) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= wwdt_mapped(raddr_r) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    chk_nmi_on_overflow: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && ovf_fire |=> watchdog_nmi_request && st_r == WWDT_PREWARN)
        else $error("overflow did not raise nmi and prewarning");
    chk_prewarn_length: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        $rose(watchdog_system_reset_request) |-> $past(pw_cnt_r) == `WWDT_PREWARN_LAST && $past(in_pw))
        else $error("reset request not after full prewarning");
    chk_invalid_no_nmi: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && inv_fire |=> st_r == WWDT_PREWARN && !watchdog_nmi_request)
        else $error("invalid service handled wrongly");
    chk_window_edge: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && wr_svc && in_run && winen_r && cif.count == {winb_r, 8'h00} |=> st_r == WWDT_PREWARN)
        else $error("service at window boundary was accepted");
    chk_window_pass: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && wr_svc && in_run && (!winen_r || cif.count > {winb_r, 8'h00}) |=> st_r == WWDT_RUN)
        else $error("service outside window was refused");
    chk_debug_hold: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && suspended && !svc_fire |=> $stable(cif.count))
        else $error("counter moved while suspended");
    chk_prewarn_sticky: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        !in_run |=> !in_run && !svc_fire)
        else $error("prewarning was cancelled");
    chk_nmi_only_ovf: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        $rose(watchdog_nmi_request) |-> $past(ovf_fire))
        else $error("nmi rose without an overflow");
    chk_reset_after_pw: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && !pw_end && !watchdog_system_reset_request |=> !watchdog_system_reset_request)
        else $error("reset request without end of prewarning");
    chk_invalid_no_reload: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && inv_fire |=> cif.count == $past(cif.count) + {15'h0000, $past(cif.tick)})
        else $error("invalid service reloaded the counter");
    chk_window_inside: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        ce && wr_svc && in_run && winen_r && cif.count < {winb_r, 8'h00} |=> in_pw && !watchdog_nmi_request)
        else $error("service inside window was accepted");
    chk_suspend_no_tick: assert property (
        @(posedge mclk) disable iff (!rst_n_r)
        suspended |-> !cif.tick)
        else $error("prescaler ticked while suspended");
endmodule : wwdt_top
`default_nettype wire

// File: verif/wwdt_cpu_model.sv
// axi4-lite master standing in for the software that services the watchdog
`timescale 1ns/1ps
`default_nettype none
module wwdt_cpu_model (
    input wire logic mclk,
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end

    // callers enter just after a rising edge; each channel drops only once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        // a spare edge so a following call never re-raises bready in the step it was lowered
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [31:0] a);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
            end
        end
        @(posedge mclk);
    endtask : rd
endmodule : wwdt_cpu_model
`default_nettype wire

// File: verif/windowed_watchdog_timer_tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_params.svh"
module windowed_watchdog_timer_tb_top;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} wwdt_note_t;
    logic mclk, arst_n, debug_mode;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic nmi, rst_req, irq;
    wwdt_note_t notes[$];
    wwdt_note_t note;
    int n_fail, tests_run, cyc, t0;
    integer seed;
    logic [7:0] r8;

    wwdt_top uut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .debug_mode(debug_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .watchdog_nmi_request(nmi), .watchdog_system_reset_request(rst_req), .irq(irq));

    wwdt_cpu_model cpu (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready));

    always #2.5 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (e !== s) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int n, input int lo, input int hi);
        tests_run++;
        if (n < lo || n > hi) begin
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
            n_fail++;
        end
    endtask : chk_rng

    task automatic wr_ok(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        cpu.wr(a, d, r);
        chk("bresp", 32'(`WWDT_RESP_OKAY), 32'(r));
    endtask : wr_ok

    // the note goes in before the request, so the watcher always finds it
    task automatic rd_exp(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] r);
        notes.push_back({d, m, r});
        cpu.rd(a);
    endtask : rd_exp

    task automatic wait_out(input bit sel, input int lim);
        int n;
        n = 0;
        while (((sel ? rst_req : nmi) !== 1'b1) && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_out

    task automatic do_reset();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask : do_reset

    always @(posedge mclk) begin
        if (rvalid && rready) begin
            note = notes.pop_front();
            chk("rdata", note.d & note.m, rdata & note.m);
            chk("rresp", 32'(note.r), 32'(rresp));
        end
    end

    // longest legal run is the slow-rate overflow, about 33k cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        logic [1:0] r;
        seed = 32'h2169_9529;
        mclk = 1'b0;
        arst_n = 1'b0;
        debug_mode = 1'b0;
        cyc = 0;
        do_reset();
        rd_exp(`WWDT_OFF_CTRL, 32'h0000_0004, '1, `WWDT_RESP_OKAY);
        rd_exp(`WWDT_OFF_RELOAD, '0, '1, `WWDT_RESP_OKAY);
        rd_exp(`WWDT_OFF_WINB, '0, '1, `WWDT_RESP_OKAY);
        rd_exp(`WWDT_OFF_IRQ_EN, '0, '1, `WWDT_RESP_OKAY);
        rd_exp(32'h0000_0020, '0, '0, `WWDT_RESP_SLVERR);
        cpu.wr(32'h0000_0020, 32'h0000_0001, r);
        chk("bresp unmapped", 32'(`WWDT_RESP_SLVERR), 32'(r));
        // overflow from a random reload near the top, then a late service
        r8 = 8'hF8 | 8'($random(seed) & 7);
        wr_ok(`WWDT_OFF_IRQ_EN, 32'h0000_0007);
        wr_ok(`WWDT_OFF_RELOAD, 32'(r8));
        wr_ok(`WWDT_OFF_SERVICE, 32'h0000_0001);
        t0 = cyc;
        rd_exp(`WWDT_OFF_COUNT, {16'h0000, r8, 8'h00}, 32'h0000_FF00, `WWDT_RESP_OKAY);
        wait_out(1'b0, 5000);
        chk_rng("overflow cycles", cyc - t0, 2 * (65536 - 256 * r8) - 8, 2 * (65536 - 256 * r8) + 8);
        chk("nmi", 32'h0000_0001, 32'(nmi));
        t0 = cyc;
        wr_ok(`WWDT_OFF_SERVICE, 32'h0000_0001);
        wait_out(1'b1, 200);
        chk_rng("prewarn cycles", cyc - t0, 90, 102);
        rd_exp(`WWDT_OFF_IRQ_STAT, 32'h0000_0005, 32'h0000_0007, `WWDT_RESP_OKAY);
        rd_exp(`WWDT_OFF_COUNT, 32'h0006_0000, 32'h0006_0000, `WWDT_RESP_OKAY);
        chk("irq", 32'h0000_0001, 32'(irq));
        wr_ok(`WWDT_OFF_IRQ_CLR, 32'h0000_0007);
        repeat (3) @(posedge mclk);
        chk("irq cleared", '0, 32'(irq));
        rd_exp(`WWDT_OFF_IRQ_STAT, '0, 32'h0000_0007, `WWDT_RESP_OKAY);
        // service inside the forbidden window, interrupt masked at first
        do_reset();
        wr_ok(`WWDT_OFF_WINB, 32'h0000_0080);
        wr_ok(`WWDT_OFF_CTRL, 32'h0000_0006);
        t0 = cyc;
        wr_ok(`WWDT_OFF_SERVICE, 32'h0000_0001);
        wait_out(1'b1, 300);
        chk_rng("invalid prewarn", cyc - t0, 90, 106);
        chk("nmi after invalid", '0, 32'(nmi));
        rd_exp(`WWDT_OFF_IRQ_STAT, 32'h0000_0006, 32'h0000_0007, `WWDT_RESP_OKAY);
        chk("irq masked", '0, 32'(irq));
        wr_ok(`WWDT_OFF_IRQ_EN, 32'h0000_0002);
        repeat (3) @(posedge mclk);
        chk("irq enabled", 32'h0000_0001, 32'(irq));
        wr_ok(`WWDT_OFF_IRQ_CLR, 32'h0000_0002);
        repeat (3) @(posedge mclk);
        chk("irq after clear", '0, 32'(irq));
        // slow rate: one tick per 128 clocks
        do_reset();
        wr_ok(`WWDT_OFF_RELOAD, 32'h0000_00FF);
        wr_ok(`WWDT_OFF_CTRL, 32'h0000_0005);
        wr_ok(`WWDT_OFF_SERVICE, 32'h0000_0001);
        t0 = cyc;
        wait_out(1'b0, 34000);
        chk_rng("slow overflow", cyc - t0, 32768 - 140, 32768 + 140);
        // debug suspension freezes the counter at its reload point
        do_reset();
        debug_mode <= 1'b1;
        repeat (4) @(posedge mclk);
        wr_ok(`WWDT_OFF_RELOAD, 32'h0000_0012);
        wr_ok(`WWDT_OFF_SERVICE, 32'h0000_0001);
        repeat (100) @(posedge mclk);
        rd_exp(`WWDT_OFF_COUNT, 32'h0000_1200, 32'h0000_FFFF, `WWDT_RESP_OKAY);
        debug_mode <= 1'b0;
        tally_and_finish();
    end
endmodule : windowed_watchdog_timer_tb_top
`default_nettype wire
